/* File: verilog/always_on_sleep_wake_config.sv */
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Eight-bit address register picks the array location fetched on direct read.
// - A direct read starts only from the trigger bit, never from address writes.
// - Offset 0x14 (index 0x05) is an eight-bit reserved location without function.
// - The configuration word acts only after an upload copies it across.
// - Automatic sleep after transmit or receive uploads and sets sleep enable itself.
// - Bit 1 lets the wake line end sleep; resets to one.
// - Bit 2 lets chip select end sleep; resets to one.
// - Bit 3 lets sleep counter expiry end sleep; resets to one.
// - Fetched byte is returned in an eight-bit result register.
// - Bit 4 selects ring oscillator or divided low-power clock for the counter.
module always_on_sleep_wake_config
    import aon_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        wake_line,
    input  wire logic        serial_chip_select_n,
    input  wire logic        ring_osc,
    input  wire logic        tx_done,
    input  wire logic        rx_done,
    output logic             sleeping,
    output logic             wake_pulse,
    output logic             count_sel_lp
);
    typedef struct packed {
        logic        access_en;
        logic [7:0]  address;
        logic [7:0]  reserved;
        logic [7:0]  result;
        logic [31:0] cfg;
        logic [1:0]  pwr;
        logic        wr_pend;
        logic [5:0]  wr_idx;
        logic [31:0] rdata;
        logic        upload;
        logic [31:0] upload_word;
        logic        rd_go;
        logic        rd_busy;
        logic [1:0]  wake_s;
        logic [1:0]  cs_s;
        logic [2:0]  osc_s;
    } regs_type;

    regs_type r_q;
    regs_type r_d;

    logic [31:0] active_cfg;
    logic        sleep_req;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        osc_tick;
    logic        addr_phase;
    logic [5:0]  addr_idx;
    logic        auto_sleep;

    // One rising ring oscillator edge per count
    assign osc_tick   = r_q.osc_s[1] && !r_q.osc_s[2];
    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign addr_idx   = haddr[7:2];
    assign auto_sleep = (tx_done && r_q.pwr[PWR_SLEEP_TX_BIT])
                     || (rx_done && r_q.pwr[PWR_SLEEP_RX_BIT]);

    // Register file, bus decode and command strobes
    always_comb begin
        r_d        = r_q;
        r_d.upload = 1'b0;
        r_d.rd_go  = 1'b0;
        // Pins are asynchronous; two stages before anything looks at them
        r_d.wake_s = {r_q.wake_s[0], wake_line};
        r_d.cs_s   = {r_q.cs_s[0], serial_chip_select_n};
        r_d.osc_s  = {r_q.osc_s[1:0], ring_osc};

        // Data phase of a write lands here
        if (r_q.wr_pend) begin
            unique case (r_q.wr_idx)
                IDX_CONTROL: begin
                    r_d.access_en = hwdata[CTRL_ENABLE_BIT];
                    // Trigger needs the enable in the same write; an enable already set does not count
                    if (hwdata[CTRL_READ_BIT] && hwdata[CTRL_ENABLE_BIT] && !r_q.rd_busy) begin
                        r_d.rd_go   = 1'b1;
                        r_d.rd_busy = 1'b1;
                    end
                    if (hwdata[CTRL_UPLOAD_BIT]) begin
                        r_d.upload      = 1'b1;
                        r_d.upload_word = r_q.cfg;
                    end
                end
                IDX_ADDRESS:    r_d.address  = hwdata[7:0];
                IDX_RESERVED:   r_d.reserved = hwdata[7:0];
                IDX_CONFIG:     r_d.cfg      = hwdata;
                IDX_POWER_CTRL: r_d.pwr      = hwdata[1:0];
                default: begin
                end
            endcase
        end

        // Automatic sleep wins over a same-cycle host write of the word
        if (auto_sleep) begin
            r_d.cfg[CFG_SLEEP_EN_BIT] = 1'b1;
            r_d.upload                = 1'b1;
            r_d.upload_word           = r_d.cfg;
        end

        // Result register fills two cycles after the fetch is issued
        if (rd_valid) begin
            r_d.result  = rd_data;
            r_d.rd_busy = 1'b0;
        end

        // Address phase: capture write target, prepare read data
        r_d.wr_pend = 1'b0;
        if (addr_phase) begin
            r_d.wr_pend = hwrite;
            r_d.wr_idx  = addr_idx;
            // Only a read reloads the data; a write leaves the last read word standing
            if (!hwrite) begin
                r_d.rdata = 32'h0000_0000;
                unique case (addr_idx)
                    IDX_CONTROL:    r_d.rdata[CTRL_ENABLE_BIT] = r_q.access_en;
                    IDX_RESULT:     r_d.rdata[7:0] = r_q.result;
                    IDX_ADDRESS:    r_d.rdata[7:0] = r_q.address;
                    IDX_RESERVED:   r_d.rdata[7:0] = r_q.reserved;
                    IDX_CONFIG:     r_d.rdata      = r_q.cfg;
                    IDX_POWER_CTRL: r_d.rdata[1:0] = r_q.pwr;
                    IDX_STATUS:     r_d.rdata[2:0] = {r_q.rd_busy, wake_pulse, sleeping};
                    default: begin
                    end
                endcase
            end
        end
    end

    // Zero-wait slave: ready and OKAY are held as flops from reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q     <= '0;
            r_q.cfg <= CFG_RESET;
            r_q.cs_s  <= 2'h3;      // Chip select idles high, so reset never looks like a wake
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            r_q       <= r_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = r_q.rdata;

    // Array and live config; the fetch address is the one held at trigger time
    aon_store #(
        .DEPTH (256)
    ) u_store (
        .clk         (clk),
        .rst_n       (rst_n),
        .upload      (r_q.upload),
        .upload_word (r_q.upload_word),
        .rd_en       (r_q.rd_go),
        .rd_addr     (r_q.address),
        .active_cfg  (active_cfg),
        .sleep_req   (sleep_req),
        .rd_data     (rd_data),
        .rd_valid    (rd_valid)
    );

    // Sleep and wake act on the uploaded copy, not the host register
    sleep_wake_ctrl u_wake (
        .clk           (clk),
        .rst_n         (rst_n),
        .cfg           (active_cfg),
        .sleep_req     (sleep_req),
        .wake_line     (r_q.wake_s[1]),
        .chip_select_n (r_q.cs_s[1]),
        .osc_tick      (osc_tick),
        .sleeping      (sleeping),
        .wake_pulse    (wake_pulse),
        .count_sel_lp  (count_sel_lp)
    );
endmodule

/* File: pkg/aon_cfg_pkg.sv */
package aon_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL     = 6'h02;
    localparam logic [5:0] IDX_RESULT      = 6'h03;
    localparam logic [5:0] IDX_ADDRESS     = 6'h04;
    localparam logic [5:0] IDX_RESERVED    = 6'h05;
    localparam logic [5:0] IDX_CONFIG      = 6'h06;
    localparam logic [5:0] IDX_POWER_CTRL  = 6'h08;
    localparam logic [5:0] IDX_STATUS      = 6'h09;

    // Control register fields
    localparam int CTRL_UPLOAD_BIT  = 2;
    localparam int CTRL_READ_BIT    = 3;
    localparam int CTRL_ENABLE_BIT  = 7;

    // Configuration word fields
    localparam int CFG_SLEEP_EN_BIT = 0;
    localparam int CFG_WAKE_PIN_BIT = 1;
    localparam int CFG_WAKE_CS_BIT  = 2;
    localparam int CFG_WAKE_BY_COUNTER_BIT = 3;
    localparam int CFG_DIV_SEL_BIT  = 4;
    localparam int CFG_DIVISOR_LSB  = 5;
    localparam int CFG_DIVISOR_W    = 11;
    localparam int CFG_SLEEP_LSB    = 16;
    localparam int CFG_SLEEP_W      = 16;
    localparam int SLEEP_SHIFT      = 12;
    localparam int SLEEP_CNT_W      = 28;
    localparam logic [31:0] CFG_RESET = 32'h50ff_1fee;

    // Power control word fields
    localparam int PWR_SLEEP_TX_BIT = 0;
    localparam int PWR_SLEEP_RX_BIT = 1;

    // Memory array layout: uploaded config bytes stand from this location
    localparam logic [7:0] MEM_CFG_BASE = 8'h00;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;
endpackage

/* File: verilog/aon_store.sv */
`timescale 1ns/1ps
// Always-on store: holds the memory array and the active configuration
module aon_store
    import aon_cfg_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        upload,
    input  wire logic [31:0] upload_word,
    input  wire logic        rd_en,
    input  wire logic [7:0]  rd_addr,
    output logic      [31:0] active_cfg,
    output logic             sleep_req,
    output logic      [7:0]  rd_data,
    output logic             rd_valid
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [31:0]           cfg;
        logic                  sleep;
        logic [7:0]            data;
        logic                  valid;
    } store_type;

    store_type s_q;
    store_type s_d;

    // Upload copies the word into the array and the live config
    always_comb begin
        s_d       = s_q;
        s_d.sleep = 1'b0;
        s_d.valid = 1'b0;
        if (upload) begin
            s_d.cfg   = upload_word;
            s_d.sleep = upload_word[CFG_SLEEP_EN_BIT];
            for (int i = 0; i < 4; i++) begin
                s_d.mem[8'(MEM_CFG_BASE + 8'(i))] = upload_word[8*i +: 8];
            end
        end
        // Fetch uses the address sampled with the trigger
        if (rd_en) begin
            s_d.data  = s_q.mem[rd_addr];
            s_d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.cfg   <= CFG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign active_cfg = s_q.cfg;
    assign sleep_req  = s_q.sleep;
    assign rd_data    = s_q.data;
    assign rd_valid   = s_q.valid;
endmodule

/* File: verilog/sleep_wake_ctrl.sv */
`timescale 1ns/1ps
// Sleep state and wake sources, acting only on the uploaded config
module sleep_wake_ctrl
    import aon_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] cfg,
    input  wire logic        sleep_req,
    input  wire logic        wake_line,
    input  wire logic        chip_select_n,
    input  wire logic        osc_tick,
    output logic             sleeping,
    output logic             wake_pulse,
    output logic             count_sel_lp
);
    typedef enum logic [1:0] {
        ST_AWAKE  = 2'b01,
        ST_ASLEEP = 2'b10
    } pm_state_type;

    typedef struct packed {
        pm_state_type             st;
        logic [SLEEP_CNT_W-1:0]   cnt;
        logic [CFG_DIVISOR_W-1:0] div;
        logic                     wake;
        logic                     sel;
    } wake_type;

    wake_type w_q;
    wake_type w_d;

    logic                   lp_tick;
    logic                   tick;
    logic [SLEEP_CNT_W-1:0] limit;
    logic                   wake_src;

    // Divisor of 0 or 1 gives a tick every cycle
    always_comb begin
        lp_tick  = (w_q.div + 11'h001 >= cfg[CFG_DIVISOR_LSB +: CFG_DIVISOR_W]);
        tick     = cfg[CFG_DIV_SEL_BIT] ? lp_tick : osc_tick;
        limit    = {cfg[CFG_SLEEP_LSB +: CFG_SLEEP_W], 12'h000};
        wake_src = (wake_line && cfg[CFG_WAKE_PIN_BIT])
                || (!chip_select_n && cfg[CFG_WAKE_CS_BIT])
                || ((w_q.cnt >= limit) && cfg[CFG_WAKE_BY_COUNTER_BIT]);
    end

    // State update; counter only runs while asleep
    always_comb begin
        w_d      = w_q;
        w_d.wake = 1'b0;
        w_d.sel  = cfg[CFG_DIV_SEL_BIT];
        w_d.div  = lp_tick ? '0 : w_q.div + 11'h001;
        unique case (w_q.st)
            ST_AWAKE: begin
                w_d.cnt = '0;
                if (sleep_req) begin
                    w_d.st = ST_ASLEEP;
                end
            end
            ST_ASLEEP: begin
                if (tick) begin
                    w_d.cnt = w_q.cnt + 28'h000_0001;
                end
                if (wake_src) begin
                    w_d.st   = ST_AWAKE;
                    w_d.wake = 1'b1;
                end
            end
            default: begin
                w_d.st = ST_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_q     <= '0;
            w_q.st  <= ST_AWAKE;
        end else begin
            w_q <= w_d;
        end
    end

    assign sleeping     = w_q.st[1];    // One-hot asleep bit, so the output is a bare flop
    assign wake_pulse   = w_q.wake;
    assign count_sel_lp = w_q.sel;
endmodule

/* File: test/always_on_sleep_wake_config_properties.sv */
`timescale 1ns/1ps
module aon_cfg_checker
    import aon_cfg_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        tx_done,
    input wire logic        rx_done,
    input wire logic        sleeping,
    input wire logic        wake_pulse,
    input wire logic        count_sel_lp
);
    logic       ctl_wr_q;
    logic [2:0] age_q;
    wire        rd_ph = hsel && hready && htrans[1] && !hwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles since the last upload cause; saturates so old uploads never excuse a change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_wr_q <= 1'h0;
            age_q    <= 3'h7;
        end else begin
            ctl_wr_q <= hsel && hready && htrans[1] && hwrite && haddr == 8'h08;
            if ((ctl_wr_q && hwdata[2]) || tx_done || rx_done)
                age_q <= 3'h0;
            else if (age_q != 3'h7)
                age_q <= age_q + 3'h1;
        end
    end
    ready_zero_wait_a: assert property (hreadyout && !hresp) else $error("bus stalled or errored");
    rdata_hold_a: assert property (!$past(rd_ph) |-> $stable(hrdata)) else $error("read data moved");
    status_sleep_a: assert property (rd_ph && haddr == 8'h24 |=> hrdata[0] == $past(sleeping))
        else $error("status sleep bit wrong");
    ctrl_selfclear_a: assert property (rd_ph && haddr == 8'h08 |=> hrdata[3:2] == 2'h0)
        else $error("command bits read back");
    unmapped_zero_a: assert property (rd_ph && haddr == 8'h28 |=> hrdata == 32'h0) else $error("unmapped not zero");
    exit_pulse_a: assert property ($fell(sleeping) |-> wake_pulse) else $error("wake without pulse");
    pulse_cause_a: assert property (wake_pulse |-> $past(sleeping) && !sleeping ##1 !wake_pulse)
        else $error("stray wake pulse");
    sleep_cause_a: assert property ($rose(sleeping) |-> age_q <= 3'h5) else $error("sleep without upload");
    div_sel_cause_a: assert property ($changed(count_sel_lp) |-> age_q <= 3'h5)
        else $error("divider select without upload");
endmodule
bind always_on_sleep_wake_config aon_cfg_checker chk_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_done(tx_done), .rx_done(rx_done), .sleeping(sleeping), .wake_pulse(wake_pulse),
    .count_sel_lp(count_sel_lp));

/* File: test/host_model.sv */
`timescale 1ns/1ps
// Host side bus master: single word transfers, waits on ready without assuming latency
module host_model (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [7:0]       haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // Bus idles until the first transfer
    initial begin
        hsel   = 1'h0;
        haddr  = 8'h00;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // Stale write data is inverted so a slave never profits from leftovers
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        hwdata <= ~hwdata;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
endmodule

/* File: test/always_on_sleep_wake_config_test.sv */
`timescale 1ns/1ps
module always_on_sleep_wake_config_test;
    import aon_cfg_pkg::*;
    logic        clk, rst_n, wake_line, cs_n, ring_osc, tx_done, rx_done, hsel, hwrite, hreadyout, hresp;
    logic        sleeping, wake_pulse, count_sel_lp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  wsel;
    logic [31:0] hwdata, hrdata, seen, cfg, rnd, rd;
    logic [31:0] q[$];
    string       nq[$];
    int          err_total = 0, n_checks = 0, m;
    event        got;
    always_on_sleep_wake_config dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .wake_line(wake_line), .serial_chip_select_n(cs_n),
        .ring_osc(ring_osc), .tx_done(tx_done), .rx_done(rx_done), .sleeping(sleeping),
        .wake_pulse(wake_pulse), .count_sel_lp(count_sel_lp));
    host_model host_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, rd);
    endtask
    task automatic note(input string n, input logic [31:0] e);
        q.push_back(e);
        nq.push_back(n);
    endtask
    task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
        note(n, e);
        host_u.xfer(1'b0, a, 32'h0, seen);
        ->got;
    endtask
    // Edge after the event lets the monitor re-arm before the next note
    task automatic chk_pin(input string n, input logic v, input logic e);
        note(n, {31'h0, e});
        seen = {31'h0, v};
        ->got;
        @(posedge clk);
    endtask
    task automatic wait_wake(input int lim);
        for (int i = 0; i < lim && wake_pulse !== 1'b1; i++) @(negedge clk);
        chk_pin("wake_pulse", wake_pulse, 1'b1);
    endtask
    // 20 MHz system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Slow free-running oscillator: one rising edge every four clocks
    initial begin
        ring_osc = 1'b0;
        forever begin repeat (2) @(posedge clk); ring_osc <= ~ring_osc; end
    end
    // Oldest note against each observed result
    initial forever begin
        @got;
        n_checks++;
        if (seen !== q[0]) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nq[0], q[0], seen);
        end
        void'(q.pop_front());
        void'(nq.pop_front());
    end
    // Counter wakes need about 16400 and 8200 clocks; everything else is short
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        end_sim();
    end
    // Registers, direct reads, each wake source and automatic sleep, in turn
    initial begin
        rst_n = 1'b0;
        wake_line = 1'b0;
        cs_n = 1'b1;
        tx_done = 1'b0;
        rx_done = 1'b0;
        rnd = $urandom(32'h3769);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_rd("config", 8'h18, 32'h50ff_1fee);
        chk_rd("unmapped", 8'h28, 32'h0000_0000);
        rnd = $urandom;
        wr(8'h10, rnd);
        chk_rd("address", 8'h10, {24'h00_0000, rnd[7:0]});
        rnd = $urandom;
        wr(8'h14, rnd);
        chk_rd("reserved", 8'h14, {24'h00_0000, rnd[7:0]});
        rnd = $urandom;
        cfg = {rnd[31:5], 5'h12};
        wr(8'h18, cfg);
        repeat (4) @(posedge clk);
        chk_pin("div_sel", count_sel_lp, 1'b0);
        wr(8'h08, 32'h0000_0004);
        repeat (4) @(posedge clk);
        chk_pin("div_sel", count_sel_lp, 1'b1);
        chk_rd("status", 8'h24, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            wr(8'h10, 32'(k));
            wr(8'h08, 32'h0000_0088);
            wr(8'h08, 32'h0000_0000);
            chk_rd("result", 8'h0c, {24'h00_0000, cfg[8*k +: 8]});
        end
        chk_rd("control", 8'h08, 32'h0000_0000);
        wr(8'h10, 32'h0000_0001);
        wr(8'h08, 32'h0000_0008);
        repeat (3) @(posedge clk);
        chk_rd("result", 8'h0c, {24'h00_0000, cfg[31:24]});
        // One wake source per pass, the others held active to prove they are ignored;
        // the last pass counts the divided clock with a divisor of two instead of the oscillator
        for (m = 0; m < 4; m++) begin
            rnd = $urandom;
            wsel = (m == 0) ? 4'h2 : (m == 1) ? 4'h4 : 4'h8;
            cfg = {16'h0001, (m == 3) ? 11'h002 : rnd[10:0], 1'(m == 3), 4'h1 | wsel};
            wr(8'h18, cfg);
            wr(8'h08, 32'h0000_0004);
            repeat (4) @(posedge clk);
            wake_line <= (m != 0);
            cs_n <= (m == 1);
            repeat (20) @(posedge clk);
            chk_pin("div_sel", count_sel_lp, 1'(m == 3));
            chk_rd("status", 8'h24, 32'h0000_0001);
            if (m == 0) begin
                wake_line <= 1'b1;
            end
            if (m == 1) begin
                cs_n <= 1'b0;
            end
            wait_wake((m >= 2) ? 20000 : 10);
            wake_line <= 1'b0;
            cs_n <= 1'b1;
            chk_rd("status", 8'h24, 32'h0000_0000);
        end
        // Automatic sleep after transmit, then after receive, each ended by the wake line
        for (m = 0; m < 2; m++) begin
            wr(8'h18, 32'h50ff_1fe2);
            wr(8'h20, 32'(m + 1));
            tx_done <= (m == 0);
            rx_done <= (m == 1);
            @(posedge clk);
            tx_done <= 1'b0;
            rx_done <= 1'b0;
            repeat (4) @(posedge clk);
            chk_rd("status", 8'h24, 32'h0000_0001);
            chk_rd("config", 8'h18, 32'h50ff_1fe3);
            wake_line <= 1'b1;
            wait_wake(10);
            wake_line <= 1'b0;
            wr(8'h20, 32'h0000_0000);
        end
        end_sim();
    end
endmodule
